// file: tb/fswdt_top_test.sv
// self-checking bench for the fail-safe watchdog timer
`timescale 1ns/1ps
module fswdt_top_test;
  `define CHK(nm, e, g) \
    begin \
      n_compared++; \
      if ((g) !== (e)) \
      begin \
        miscompares++; \
        $display("[ERR] %s exp %h got %h", nm, e, g); \
      end \
    end
  logic clk, rst, stp, wup, idl, slp, awv, wv, bri, arv, rri;
  logic [7:0] awa, ara;
  logic [31:0] wd;
  logic [3:0] ws;
  logic awr, wrd, bv, arr, rv, rq, iq;
  logic [1:0] br, rr;
  logic [31:0] rdt, s;
  logic [1:0] r;
  int miscompares, n_compared, n_rst, n_irq, n, m, c, k;
  ////////////////////////////////////////////////////////////////////////
  fswdt_top #(.DIV_W(8), .ADDR_W(8)) fswdt_top_i (
    .core_clk_i(clk), .sys_rst_i(rst), .stop_mode_i(stp), .warmup_i(wup),
    .idle_mode_i(idl), .sleep_mode_i(slp),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv),
    .s_axi_bready(bri), .s_axi_bresp(br), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rv), .s_axi_rready(rri), .s_axi_rdata(rdt),
    .s_axi_rresp(rr), .wdt_reset_req_o(rq), .timeout_interrupt_o(iq));
  always #20 clk = ~clk;
  // pulse counters, sampled where outputs are settled
  always @(negedge clk)
  begin
    if (rq === 1'b1) n_rst++;
    if (iq === 1'b1) n_irq++;
  end
  ////////////////////////////////////////////////////////////////////////
  // waits for the answer however long; only the watchdog ends a hang
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bri <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wrd === 1'b1) wv <= 1'b0;
      if (bv === 1'b1) break;
    end
    bri <= 1'b0;
    `CHK("bresp", fswdt_pkg::RESP_OKAY, br)
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rri <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (arr === 1'b1) arv <= 1'b0;
      if (rv === 1'b1) break;
    end
    d = rdt;
    e = rr;
    rri <= 1'b0;
  endtask
  task st(output logic [31:0] v);
    logic [1:0] e;
    rd(fswdt_pkg::STAT_ADDR, v, e);
    `CHK("status resp", fswdt_pkg::RESP_OKAY, e)
  endtask
  task idle(input int cy);
    repeat (cy) @(posedge clk);
  endtask
  task print_verdict;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict;
  end
  initial
  begin
    clk = 0; rst = 1; {stp, wup, idl, slp} = 4'h0;
    {awv, wv, bri, arv, rri} = 5'h0;
    awa = 8'h00; ara = 8'h00; wd = 32'h0; ws = 4'hF;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    st(s);
    `CHK("status after reset", 32'h00000007, s)
    rd(8'hFC, s, r);
    `CHK("unmapped resp", fswdt_pkg::RESP_SLVERR, r)
    idle(300);
    st(s);
    `CHK("counter", 2'h1, s[6:5])
    for (k = 0; k < 4; k++)
    begin
      {slp, idl, wup, stp} <= 4'h1 << k;
      idle(300);
      st(s);
      `CHK("frozen counter", 2'h1, s[6:5])
      {slp, idl, wup, stp} <= 4'h0;
      idle(2);
    end
    idle(256);
    st(s);
    `CHK("resumed counter", 2'h2, s[6:5])
    wr(fswdt_pkg::CODE_ADDR, fswdt_pkg::CODE_CLEAR);
    wr(fswdt_pkg::CTRL_ADDR, 8'h0D);
    n = n_rst;
    repeat (10)
    begin
      idle(30);
      wr(fswdt_pkg::CODE_ADDR, fswdt_pkg::CODE_CLEAR);
    end
    `CHK("no reset while cleared", n, n_rst)
    repeat (4)
    begin
      idle(30);
      wr(fswdt_pkg::CODE_ADDR, 8'h55);
    end
    `CHK("reset after bad code", 1'b1, n_rst > n)
    `CHK("no irq in reset mode", 0, n_irq)
    wr(fswdt_pkg::CTRL_ADDR, 8'h0F);
    wr(fswdt_pkg::CODE_ADDR, fswdt_pkg::CODE_CLEAR);
    for (c = 0; c < 40; c++)
    begin
      @(posedge clk);
      if (rq) break;
    end
    // detection 16 cycles: overflow 12 to 16 cycles after the clear
    `CHK("clear to timeout", 1'b1, c >= 11 && c <= 15)
    wr(fswdt_pkg::CODE_ADDR, fswdt_pkg::CODE_DISABLE);
    st(s);
    `CHK("disable refused", 1'b1, s[0])
    wr(fswdt_pkg::CODE_ADDR, fswdt_pkg::CODE_CLEAR);
    n = n_rst;
    m = n_irq;
    wr(fswdt_pkg::CTRL_ADDR, 8'h0E);
    idle(100);
    `CHK("periodic irq", 1'b1, n_irq >= m + 5)
    `CHK("no reset in irq mode", n, n_rst)
    wr(fswdt_pkg::CTRL_ADDR, 8'h0F);
    st(s);
    `CHK("action locked", 1'b0, s[2])
    `CHK("detection field", 2'h3, s[4:3])
    // detection 256 cycles: no overflow before 192, one by 256
    wr(fswdt_pkg::CTRL_ADDR, 8'h0A);
    wr(fswdt_pkg::CODE_ADDR, fswdt_pkg::CODE_CLEAR);
    m = n_irq;
    idle(180);
    `CHK("no early slow irq", m, n_irq)
    idle(80);
    `CHK("one slow irq", m + 1, n_irq)
    wr(fswdt_pkg::CODE_ADDR, fswdt_pkg::CODE_CLEAR);
    wr(fswdt_pkg::CTRL_ADDR, 8'h06);
    wr(fswdt_pkg::CODE_ADDR, fswdt_pkg::CODE_DISABLE);
    st(s);
    `CHK("disabled", 3'h0, {s[6:5], s[0]})
    m = n_irq;
    idle(100);
    `CHK("silent when disabled", m, n_irq)
    print_verdict;
  end
endmodule // fswdt_top_test

// file: verilog/fswdt_pkg.sv
// constants of the fail-safe watchdog timer
package fswdt_pkg;
  // register indices; byte address is four times the index
  localparam int unsigned CTRL_IDX = 32'h34;
  localparam int unsigned CODE_IDX = 32'h35;
  localparam int unsigned STAT_IDX = 32'h36;
  localparam logic [7:0] CTRL_ADDR = 8'(CTRL_IDX * 4);
  localparam logic [7:0] CODE_ADDR = 8'(CODE_IDX * 4);
  localparam logic [7:0] STAT_ADDR = 8'(STAT_IDX * 4);
  // control one fields
  localparam int ACT_BIT = 0;
  localparam int DTS_LSB = 1;
  localparam int EN_BIT = 3;
  // codes written to the code register
  localparam logic [7:0] CODE_CLEAR = 8'h4E;
  localparam logic [7:0] CODE_DISABLE = 8'hB1;
  // status fields
  localparam int ST_RUN = 0;
  localparam int ST_EN = 1;
  localparam int ST_ACT = 2;
  localparam int ST_DTS = 3;
  localparam int ST_BIN = 5;
  // reset values
  localparam logic RST_EN = 1'b1;
  localparam logic RST_ACT = 1'b1;
  localparam logic [1:0] RST_DTS = 2'h0;
  // two-stage binary counter
  localparam logic [1:0] BIN_MAX = 2'h3;
  // each detection-time step shortens the divider tap by this
  localparam int DTS_STEP = 2;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: verilog/fswdt_top.sv
// fail-safe watchdog timer with axi4-lite register slave
`timescale 1ns/1ps
// Summary of operation
// - timeout action fixed once interrupt is chosen
// - after reset the action is reset request
// - may serve as periodic interrupt source
// - watchdog enabled and counting after reset
// - timeout when counter overflows without clear
// - select one gives reset request on overflow
// - select zero gives timeout interrupt on overflow
// - count frozen in stop, warm-up, idle, sleep
// - counting resumes from the held value
// - free divider then two-stage binary counter
// - clear code zeroes counter, divider keeps running
// - clear to overflow may be three quarters
// - select once zero cannot return to one
// - disable code accepted only with enable zero
// - timeout interrupt is non-maskable
module fswdt_top #(
  parameter int DIV_W = 24,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // low-power modes from the core
  input wire logic stop_mode_i,
  input wire logic warmup_i,
  input wire logic idle_mode_i,
  input wire logic sleep_mode_i,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // timeout outputs
  output logic wdt_reset_req_o,
  output logic timeout_interrupt_o
);

  typedef struct packed {
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [7:0] w_data;
    logic w_lane;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic en_bit;
    logic running;
    logic action;
    logic [1:0] dts;
    logic [DIV_W-1:0] div;
    logic [1:0] bin;
    logic rst_req;
    logic irq;
  } fswdt_state_t;

  fswdt_state_t q;
  fswdt_state_t n;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] ba);
    hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(ba[7:2]));
  endfunction

  // low divider bits that must all be one for a tap tick
  function automatic logic [DIV_W-1:0] tap_mask(input logic [1:0] sel);
    logic [DIV_W-1:0] m;
    m = '1;
    tap_mask = m >> (fswdt_pkg::DTS_STEP * int'(sel));
  endfunction

  logic frozen;
  logic tick;
  logic wr_fire;
  logic wr_ok;
  logic clr_w;
  logic dis_w;
  logic ctl_w;
  logic oth_w;
  logic ovf;

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    n = q;
    frozen = stop_mode_i | warmup_i | idle_mode_i | sleep_mode_i;
    tick = !frozen && ((q.div | ~tap_mask(q.dts)) == '1);
    wr_fire = q.aw_have && q.w_have && !q.bvalid;
    wr_ok = wr_fire && q.w_lane;
    ctl_w = wr_ok && hit(q.aw_addr, fswdt_pkg::CTRL_ADDR);
    clr_w = wr_ok && hit(q.aw_addr, fswdt_pkg::CODE_ADDR)
            && q.w_data == fswdt_pkg::CODE_CLEAR;
    dis_w = wr_ok && hit(q.aw_addr, fswdt_pkg::CODE_ADDR)
            && q.w_data == fswdt_pkg::CODE_DISABLE;
    oth_w = wr_ok && hit(q.aw_addr, fswdt_pkg::CODE_ADDR)
            && !clr_w && !dis_w;
    // divider is cleared only by reset, otherwise only paused
    if (!frozen)
    begin
      n.div = q.div + {{(DIV_W-1){1'b0}}, 1'b1};
    end
    // two-stage counter counts divider taps
    if (!q.running)
    begin
      n.bin = '0;
    end
    else if (tick)
    begin
      n.bin = q.bin + 2'h1;
    end
    // a clear in the overflow cycle wins
    ovf = q.running && tick && q.bin == fswdt_pkg::BIN_MAX && !clr_w;
    n.rst_req = ovf && q.action;
    n.irq = ovf && !q.action;
    // register writes
    if (ctl_w)
    begin
      n.dts = q.w_data[fswdt_pkg::DTS_LSB +: 2];
      n.en_bit = q.w_data[fswdt_pkg::EN_BIT];
      if (q.w_data[fswdt_pkg::EN_BIT])
      begin
        n.running = 1'b1;
      end
      n.action = q.action & q.w_data[fswdt_pkg::ACT_BIT];
    end
    if (clr_w)
    begin
      n.bin = '0;
    end
    if (dis_w && !q.en_bit)
    begin
      n.running = 1'b0;
      n.bin = '0;
    end
    // oth_w touches nothing
    // write channels
    if (s_axi_awvalid && q.awready)
    begin
      n.aw_have = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready)
    begin
      n.w_have = 1'b1;
      n.w_data = s_axi_wdata[7:0];
      n.w_lane = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready)
    begin
      n.bvalid = 1'b0;
    end
    if (wr_fire)
    begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (hit(q.aw_addr, fswdt_pkg::CTRL_ADDR)
                 || hit(q.aw_addr, fswdt_pkg::CODE_ADDR))
                ? fswdt_pkg::RESP_OKAY : fswdt_pkg::RESP_SLVERR;
    end
    n.awready = !n.aw_have;
    n.wready = !n.w_have;
    // read channels
    if (q.rvalid && s_axi_rready)
    begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready)
    begin
      n.rvalid = 1'b1;
      n.rdata = '0;
      n.rresp = fswdt_pkg::RESP_OKAY;
      if (hit(s_axi_araddr, fswdt_pkg::STAT_ADDR))
      begin
        n.rdata[fswdt_pkg::ST_RUN] = q.running;
        n.rdata[fswdt_pkg::ST_EN] = q.en_bit;
        n.rdata[fswdt_pkg::ST_ACT] = q.action;
        n.rdata[fswdt_pkg::ST_DTS +: 2] = q.dts;
        n.rdata[fswdt_pkg::ST_BIN +: 2] = q.bin;
      end
      else if (!hit(s_axi_araddr, fswdt_pkg::CTRL_ADDR)
               && !hit(s_axi_araddr, fswdt_pkg::CODE_ADDR))
      begin
        n.rresp = fswdt_pkg::RESP_SLVERR;
      end
    end
    n.arready = !n.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      q <= '0;
      q.en_bit <= fswdt_pkg::RST_EN;
      q.running <= fswdt_pkg::RST_EN;
      q.action <= fswdt_pkg::RST_ACT;
      q.dts <= fswdt_pkg::RST_DTS;
    end
    else
    begin
      q <= n;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign wdt_reset_req_o = q.rst_req;
  assign timeout_interrupt_o = q.irq;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_ovf;
    q.running && tick && q.bin == fswdt_pkg::BIN_MAX && !clr_w;
  endsequence

  sequence s_pause;
    frozen && !wr_fire;
  endsequence

  property p_reset_default;
    $past(sys_rst_i) |-> q.action && q.running && q.en_bit;
  endproperty
  a_reset_default: assert property (p_reset_default)
    else $error("watchdog not armed for reset after reset");

  property p_action_once;
    !q.action |=> !q.action [*8];
  endproperty
  a_action_once: assert property (p_action_once)
    else $error("timeout action returned to reset");

  property p_ovf_reset;
    s_ovf ##0 q.action |=> wdt_reset_req_o && !timeout_interrupt_o
      ##1 !wdt_reset_req_o;
  endproperty
  a_ovf_reset: assert property (p_ovf_reset)
    else $error("overflow did not pulse reset request");

  property p_ovf_irq;
    s_ovf ##0 !q.action |=> timeout_interrupt_o && !wdt_reset_req_o;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq)
    else $error("overflow did not raise timeout interrupt");

  property p_no_spurious;
    !(q.running && tick && q.bin == fswdt_pkg::BIN_MAX)
      |=> !wdt_reset_req_o && !timeout_interrupt_o;
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("timeout without overflow");

  property p_frozen;
    s_pause |=> $stable(q.div) && $stable(q.bin);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("count moved while frozen");

  property p_clear;
    clr_w && !frozen |=> q.bin == 2'h0
      && q.div == $past(q.div) + {{(DIV_W-1){1'b0}}, 1'b1};
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear code misbehaved");

  property p_disable_guard;
    dis_w && q.en_bit |=> q.running;
  endproperty
  a_disable_guard: assert property (p_disable_guard)
    else $error("disable accepted while enable bit set");

  property p_ignore_other;
    oth_w && !ctl_w |=> $stable(q.running) && $stable(q.en_bit);
  endproperty
  a_ignore_other: assert property (p_ignore_other)
    else $error("unknown code changed state");

  property p_write_resp;
    wr_fire |=> s_axi_bvalid;
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("write not answered");

endmodule // fswdt_top
